// [include/ams_pkg.sv]
package ams_pkg;

    // clock and timing
    localparam int CLK_MHZ    = 40;
    localparam int WAKE_US    = 20;
    localparam int WAKE_CYC   = WAKE_US * CLK_MHZ;
    localparam int SETTLE_MS  = 15;
    localparam int SETTLE_CYC = SETTLE_MS * 1000 * CLK_MHZ;
    localparam int WAKE_W     = 10;
    localparam int SETTLE_W   = 20;

    // frame bit counts
    localparam int       CMD_BITS   = 16;
    localparam int       FULL_BITS  = 32;
    localparam int       BIT_W      = 6;
    localparam logic [5:0] BITCNT_MAX = 6'h3F;

    // command words
    localparam logic [15:0] CMD_KEEP      = 16'h0000;
    localparam logic [15:0] CMD_STANDBY   = 16'h8200;
    localparam logic [15:0] CMD_POWERDOWN = 16'h8300;
    localparam logic [15:0] CMD_AUTO      = 16'hA000;
    localparam logic [15:0] CMD_MAN_BASE  = 16'hC000;
    localparam logic [15:0] CMD_MAN_MASK  = 16'hE3FF;
    localparam logic [15:0] CMD_AUX       = 16'hE000;
    localparam int          MAN_CH_LSB    = 10;

    // channels and buffering
    localparam int NCH        = 8;
    localparam int RANGE_W    = 4;
    localparam int FIFO_DEPTH = 32;

    // reset values
    localparam logic RST_PIN_CS   = 1'b1;
    localparam logic RST_PIN_SCLK = 1'b0;

    typedef enum logic [2:0] {
        AMS_IDLE,
        AMS_STANDBY,
        AMS_POWERDOWN,
        AMS_AUTO,
        AMS_MANUAL
    } ams_mode_e;

    typedef struct packed {
        logic               aux;
        logic [2:0]         chan;
        logic [RANGE_W-1:0] range;
        logic               settled;
    } ams_sample_s;

    typedef struct packed {
        logic                cs_m;
        logic                cs_s;
        logic                cs_q;
        logic                sclk_m;
        logic                sclk_s;
        logic                sclk_q;
        logic                sdi_m;
        logic                sdi_s;
        logic [15:0]         shift;
        logic [BIT_W-1:0]    bitcnt;
        ams_mode_e           mode;
        logic [2:0]          auto_chan;
        logic [2:0]          man_chan;
        logic                aux_channel_command;
        logic                pend;
        ams_sample_s         pend_data;
        logic [WAKE_W-1:0]   wake_cnt;
        logic [SETTLE_W-1:0] settle_cnt;
        logic                wake_busy;
        logic                settle_busy;
        logic                ref_on;
        logic                core_on;
        logic [NCH-1:0]      chan_pwr;
        logic                data_invalid;
        logic                sample_lost;
    } ams_state_s;

endpackage

// [rtl/ams_fifo.sv]
`timescale 1ns/100ps
module ams_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 32
) (
    input  wire logic         clock,     // system clock
    input  wire logic         rst_n,     // synchronised reset, active low
    input  wire logic         in_valid,  // write request
    input  wire logic [W-1:0] in_data,   // write word
    output logic              in_ready,  // room for a word
    output logic              out_valid, // output register holds a word
    output logic [W-1:0]      out_data,  // output register
    input  wire logic         out_ready  // consumer takes the word
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          push;
    logic          pop;

    // output stage is a register, so the store counts only words behind it
    assign in_ready = cnt != (AW+1)'(DEPTH);
    assign push     = in_valid && in_ready;
    assign pop      = (cnt != '0) && (!out_valid || out_ready);

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    // pointers wrap naturally because depth is a power of two
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wp        <= '0;
            rp        <= '0;
            cnt       <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            if (push) begin
                wp <= wp + 1'b1;
            end
            if (pop) begin
                rp       <= rp + 1'b1;
                out_data <= mem[rp];
            end
            cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
            if (pop) begin
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule

// [rtl/ams_sequencer.sv]
`timescale 1ns/100ps
// What this block does
// - Standby command at frame end enters standby, reference and buffer stay powered.
// - Leaving standby keeps all configured settings untouched.
// - Standby persists until an auto-scan, manual or power-down command executes.
// - In standby, a 32-clock frame flags its conversion data invalid.
// - Conversion command leaves standby at frame end, sampling at next frame start.
// - Power-down command at frame end turns off everything including reference.
// - Waking from software power-down keeps settings.
// - Power-down persists without a conversion or standby command; 32-clock frames flag invalid data.
// - Valid command exits power-down; internal reference needs settling time first.
// - Auto-scan command starts scanning the channels enabled in the scan mask.
// - Auto-scan converts enabled channels ascending, one per frame, wrapping around.
// - Repeating the auto-scan command restarts from the lowest enabled channel.
// - Auto-scan persists while no other valid command executes.
// - Manual command samples that channel next frame and keeps doing so.
// - In auto-scan, channels outside the scan mask are powered down.
// - Each channel sample uses the range programmed for its own channel; auxiliary samples carry range 0.
// - Manual codes carry channel in bits 12..10; E000h selects auxiliary.
// - An all-zero command word keeps the last mode and settings.
module ams_sequencer
    import ams_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC
) (
    input  wire logic                          clock,                   // 40 MHz clock
    input  wire logic                          resetn,                  // async reset, low
    input  wire logic                          cs_n,                    // chip select pin
    input  wire logic                          sclk,                    // serial clock pin
    input  wire logic                          sdi,                     // serial data pin
    input  wire logic [NCH-1:0]                scan_enable,             // auto-scan mask
    input  wire logic [NCH-1:0][RANGE_W-1:0]   range_sel,               // range per channel
    input  wire logic                          reference_source_select, // 1 = external ref
    input  wire logic                          sample_ready,            // converter takes
    output logic                               sample_valid,            // sample request
    output ams_sample_s                        sample_data,             // channel and range
    output ams_mode_e                          mode,                    // current mode
    output logic                               ref_power_on,            // ref and buffer on
    output logic                               core_power_on,           // core circuits on
    output logic [NCH-1:0]                     channel_power,           // front-end power
    output logic                               wake_busy,               // standby wake-up
    output logic                               settle_busy,             // reference settling
    output logic                               data_invalid,            // last frame invalid
    output logic                               sample_lost              // request dropped
);

    logic        rst_m;
    logic        rst_n;
    ams_state_s  s;
    ams_state_s  n;
    logic        cs_fall;
    logic        cs_rise;
    logic        sclk_fall;
    logic        exec;
    logic [15:0] cmd;
    logic        is_man;
    logic        is_conv;
    logic        conv_mode;
    logic        fifo_in_ready;
    logic [2:0]  lowest_chan;
    logic [2:0]  pick_chan;

    // lowest enabled channel at or after start, wrapping; start if mask is empty
    function automatic logic [2:0] ams_pick(input logic [NCH-1:0] m, input logic [2:0] st);
        logic [2:0] r;
        logic [2:0] c;
        r = st;
        for (int i = NCH - 1; i >= 0; i--) begin
            c = st + 3'(i);
            if (m[c]) begin
                r = c;
            end
        end
        return r;
    endfunction

    // reset release through two flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    // edges are taken from the second and third flops, never from the first
    assign cs_fall   = s.cs_q & ~s.cs_s;
    assign cs_rise   = ~s.cs_q & s.cs_s;
    assign sclk_fall = s.sclk_q & ~s.sclk_s & ~s.cs_s;
    assign cmd       = s.shift;
    assign exec      = cs_rise && (s.bitcnt >= BIT_W'(CMD_BITS));
    assign is_man    = (cmd & CMD_MAN_MASK) == CMD_MAN_BASE;
    assign is_conv   = (cmd == CMD_AUTO) || is_man || (cmd == CMD_AUX);
    assign conv_mode = (s.mode == AMS_AUTO) || (s.mode == AMS_MANUAL);
    assign lowest_chan = ams_pick(scan_enable, 3'h0);
    assign pick_chan   = ams_pick(scan_enable, s.auto_chan);

    always_comb begin
        n = s;
        n.sample_lost = 1'b0;
        // pin synchronisers
        n.cs_m   = cs_n;
        n.cs_s   = s.cs_m;
        n.cs_q   = s.cs_s;
        n.sclk_m = sclk;
        n.sclk_s = s.sclk_m;
        n.sclk_q = s.sclk_s;
        n.sdi_m  = sdi;
        n.sdi_s  = s.sdi_m;
        // wake-up and settling counters run down on their own
        if (s.wake_cnt != '0) begin
            n.wake_cnt = s.wake_cnt - 1'b1;
        end
        if (s.settle_cnt != '0) begin
            n.settle_cnt = s.settle_cnt - 1'b1;
        end
        // hand the pending request to the buffer; a full buffer stalls it here
        if (s.pend && fifo_in_ready) begin
            n.pend = 1'b0;
        end
        // command bits are taken on the first 16 falling clock edges
        if (sclk_fall) begin
            if (s.bitcnt < BIT_W'(CMD_BITS)) begin
                n.shift = {s.shift[14:0], s.sdi_s};
            end
            if (s.bitcnt != BITCNT_MAX) begin
                n.bitcnt = s.bitcnt + 1'b1;
            end
        end
        // frame start: sample in a conversion mode
        if (cs_fall) begin
            n.bitcnt = '0;
            n.shift  = '0;
            if (conv_mode) begin
                n.sample_lost       = s.pend && !fifo_in_ready;
                n.pend              = 1'b1;
                n.pend_data.settled = (s.wake_cnt == '0) && (s.settle_cnt == '0);
                if (s.mode == AMS_AUTO) begin
                    n.pend_data.aux   = 1'b0;
                    n.pend_data.chan  = pick_chan;
                    n.pend_data.range = range_sel[pick_chan];
                    n.auto_chan       = ams_pick(scan_enable, pick_chan + 3'h1);
                end else begin
                    n.pend_data.aux   = s.aux_channel_command;
                    n.pend_data.chan  = s.man_chan;
                    n.pend_data.range = s.aux_channel_command ? '0 : range_sel[s.man_chan];
                end
            end
        end
        // frame end: judge the frame, then execute the command it carried
        if (cs_rise) begin
            n.data_invalid = !conv_mode && (s.bitcnt >= BIT_W'(FULL_BITS));
        end
        // settings live outside this block and are never reset here
        if (exec) begin
            if (cmd == CMD_STANDBY) begin
                n.mode    = AMS_STANDBY;
                n.ref_on  = 1'b1;
                n.core_on = 1'b0;
            end else if (cmd == CMD_POWERDOWN) begin
                n.mode    = AMS_POWERDOWN;
                n.ref_on  = 1'b0;
                n.core_on = 1'b0;
            end else if (is_conv) begin
                n.ref_on  = 1'b1;
                n.core_on = 1'b1;
                if (s.mode == AMS_STANDBY || s.mode == AMS_IDLE) begin
                    n.wake_cnt = WAKE_W'(WAKE_CYC);
                end
                if (cmd == CMD_AUTO) begin
                    n.mode      = AMS_AUTO;
                    n.auto_chan = lowest_chan;
                end else begin
                    n.mode     = AMS_MANUAL;
                    n.aux_channel_command  = cmd == CMD_AUX;
                    n.man_chan = cmd[MAN_CH_LSB +: 3];
                end
            end
            // in power-down, any non-keep word other than power-down re-arms settling of the internal reference
            if (s.mode == AMS_POWERDOWN && cmd != CMD_KEEP && cmd != CMD_POWERDOWN
                && !reference_source_select) begin
                n.settle_cnt = SETTLE_W'(SETTLE_CYCLES);
            end
        end
        // an all-zero word or an unknown word falls through and keeps the mode
        // front-end power follows the mode
        unique case (n.mode)
            AMS_AUTO:   n.chan_pwr = scan_enable;
            AMS_MANUAL: n.chan_pwr = n.aux_channel_command ? '0 : NCH'(1) << n.man_chan;
            AMS_IDLE, AMS_STANDBY, AMS_POWERDOWN: n.chan_pwr = '0;
        endcase
        n.wake_busy   = n.wake_cnt != '0;
        n.settle_busy = n.settle_cnt != '0;
    end

    // all state in one register; chip select idles high
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s        <= '0;
            s.cs_m   <= RST_PIN_CS;
            s.cs_s   <= RST_PIN_CS;
            s.cs_q   <= RST_PIN_CS;
            s.sclk_m <= RST_PIN_SCLK;
            s.sclk_s <= RST_PIN_SCLK;
            s.sclk_q <= RST_PIN_SCLK;
        end else begin
            s <= n;
        end
    end

    // 32-word buffer between the sequencer and the converter
    ams_fifo #(
        .W     ($bits(ams_sample_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (s.pend),
        .in_data   (s.pend_data),
        .in_ready  (fifo_in_ready),
        .out_valid (sample_valid),
        .out_data  (sample_data),
        .out_ready (sample_ready)
    );

    assign mode          = s.mode;
    assign ref_power_on  = s.ref_on;
    assign core_power_on = s.core_on;
    assign channel_power = s.chan_pwr;
    assign wake_busy     = s.wake_busy;
    assign settle_busy   = s.settle_busy;
    assign data_invalid  = s.data_invalid;
    assign sample_lost   = s.sample_lost;

    // helper state read only by the checks below
    logic [WAKE_W:0]               wake_len;
    logic [SETTLE_W:0]             settle_len;
    logic [NCH-1:0]                scan_q;
    logic [NCH-1:0][RANGE_W-1:0]   range_q;
    // a reload restarts each length count, so a re-armed interval is measured from its start
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wake_len   <= '0;
            settle_len <= '0;
            scan_q     <= '0;
            range_q    <= '0;
        end else begin
            if (s.wake_cnt == WAKE_W'(WAKE_CYC)) begin
                wake_len <= (WAKE_W+1)'(1);
            end else begin
                wake_len <= s.wake_busy ? wake_len + 1'b1 : '0;
            end
            if (s.settle_cnt == SETTLE_W'(SETTLE_CYCLES)) begin
                settle_len <= (SETTLE_W+1)'(1);
            end else begin
                settle_len <= s.settle_busy ? settle_len + 1'b1 : '0;
            end
            scan_q     <= scan_enable;
            range_q    <= range_sel;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence exec_cmd(logic [15:0] c);
        exec && (cmd == c);
    endsequence

    sequence wake_run;
        s.wake_busy [*8];
    endsequence

    standby_entry_a: assert property (exec_cmd(CMD_STANDBY) |=>
        s.mode == AMS_STANDBY && s.ref_on && !s.core_on)
        else $error("standby not entered with reference on");
    powerdown_entry_a: assert property (exec_cmd(CMD_POWERDOWN) |=>
        s.mode == AMS_POWERDOWN && !s.ref_on && !s.core_on ##1 s.chan_pwr == '0)
        else $error("power-down left something powered");
    keep_mode_a: assert property (exec_cmd(CMD_KEEP) |=> s.mode == $past(s.mode))
        else $error("all-zero word changed the mode");
    standby_hold_a: assert property (s.mode == AMS_STANDBY && !exec |=>
        s.mode == AMS_STANDBY)
        else $error("standby left without a command");
    powerdown_hold_a: assert property (s.mode == AMS_POWERDOWN && !exec |=>
        s.mode == AMS_POWERDOWN)
        else $error("power-down left without a command");
    standby_exit_a: assert property (s.mode == AMS_STANDBY && exec && is_conv |=>
        wake_run ##0 s.core_on)
        else $error("standby exit did not start wake-up");
    wake_length_a: assert property ($fell(s.wake_busy) |-> wake_len == WAKE_CYC)
        else $error("wake-up interval has the wrong length");
    settle_start_a: assert property (s.mode == AMS_POWERDOWN && exec && is_conv
        && !reference_source_select |=> s.settle_busy && s.settle_cnt == SETTLE_W'(SETTLE_CYCLES))
        else $error("reference settling not started");
    auto_restart_a: assert property (exec_cmd(CMD_AUTO) |=>
        s.mode == AMS_AUTO && s.auto_chan == $past(lowest_chan))
        else $error("auto-scan did not restart at lowest channel");
    auto_sample_a: assert property (cs_fall && s.mode == AMS_AUTO && |scan_enable |=>
        s.pend && !s.pend_data.aux && scan_q[s.pend_data.chan])
        else $error("auto-scan sampled a disabled channel");
    manual_hold_a: assert property (cs_fall && s.mode == AMS_MANUAL |=>
        s.pend && s.pend_data.chan == s.man_chan && s.pend_data.aux == s.aux_channel_command)
        else $error("manual mode sampled another channel");
    range_pick_a: assert property ($rose(s.pend) && !s.pend_data.aux |->
        s.pend_data.range == range_q[s.pend_data.chan])
        else $error("sample carries another channel's range");
    invalid_data_a: assert property (cs_rise && !conv_mode
        && s.bitcnt >= BIT_W'(FULL_BITS) |=> s.data_invalid)
        else $error("32-clock frame in low power not flagged");
    scan_power_a: assert property (s.mode == AMS_AUTO |-> s.chan_pwr == $past(scan_enable))
        else $error("channel power does not follow scan mask");

    // levels must hold between commands, not only at the edge that sets them
    mode_stable_a: assert property (!exec |=> $stable(s.mode))
        else $error("mode changed outside an executed command");
    idle_quiet_a: assert property (s.mode == AMS_IDLE |-> !s.core_on && s.chan_pwr == '0)
        else $error("circuitry powered while idle");
    auto_hold_a: assert property (s.mode == AMS_AUTO && !exec |=> s.mode == AMS_AUTO)
        else $error("auto-scan left without a command");
    manual_keep_a: assert property (s.mode == AMS_MANUAL && !exec |=>
        $stable(s.man_chan) && $stable(s.aux_channel_command))
        else $error("manual channel changed without a command");
    manual_power_a: assert property (s.mode == AMS_MANUAL && !s.aux_channel_command |->
        s.chan_pwr == (NCH'(1) << s.man_chan))
        else $error("manual channel front end not powered alone");
    standby_power_a: assert property (s.mode == AMS_STANDBY |->
        s.ref_on && !s.core_on && s.chan_pwr == '0)
        else $error("standby power levels wrong");
    powerdown_power_a: assert property (s.mode == AMS_POWERDOWN |->
        !s.ref_on && !s.core_on && s.chan_pwr == '0)
        else $error("circuitry powered during power-down");
    valid_clear_a: assert property (cs_rise && conv_mode |=> !s.data_invalid)
        else $error("conversion frame flagged invalid");
    aux_range_a: assert property ($rose(s.pend) && s.pend_data.aux |->
        s.pend_data.range == '0)
        else $error("auxiliary sample carries a channel range");
    settle_length_a: assert property ($fell(s.settle_busy) |->
        settle_len == SETTLE_CYCLES)
        else $error("settling interval has the wrong length");
endmodule

// [verif/ams_host_model.sv]
`timescale 1ns/100ps
module ams_host_model
    import ams_pkg::*;
(
    input  wire logic clock, // system clock
    output logic      cs_n,  // chip select, low within a frame
    output logic      sclk,  // serial clock, stands low outside frames
    output logic      sdi    // command bits, msb first
);
    // idle pins before the first frame
    initial begin
        cs_n = RST_PIN_CS;
        sclk = RST_PIN_SCLK;
        sdi = 1'b0;
    end

    // one frame: hold stretches the select before clocking, for the wake-up
    task automatic frame(input logic [15:0] w, input int nb, input int hold);
        @(posedge clock) cs_n <= 1'b0;
        repeat (3 + hold) @(posedge clock);
        for (int i = 0; i < nb; i++) begin
            @(posedge clock) sclk <= 1'b1;
            sdi <= (i < CMD_BITS) ? w[15-i] : 1'b0;
            repeat (2) @(posedge clock);
            @(posedge clock) sclk <= 1'b0;
            repeat (2) @(posedge clock);
        end
        @(posedge clock) cs_n <= 1'b1;
        sdi <= ~sdi; // released line: no stale level for the device to trust
        repeat (8) @(posedge clock);
    endtask
endmodule

// [verif/tb_ams_sequencer.sv]
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
    $display("mismatch at %0t: got %0h exp %0h", $time, (a), (e)); end end
module tb_ams_sequencer
    import ams_pkg::*;
;
    localparam int SETTLE_SIM = 50;
    logic clock, resetn, cs_n, sclk, sdi, reference_source_select, sample_ready;
    logic [NCH-1:0] scan_enable, channel_power;
    logic [NCH-1:0][RANGE_W-1:0] range_sel;
    logic sample_valid, ref_power_on, core_power_on, wake_busy, settle_busy;
    logic data_invalid, sample_lost, cur_aux, auto_on, settled_exp;
    ams_sample_s sample_data;
    ams_mode_e mode;
    logic [2:0] cur_ch;
    int err_total, total_checks, lost, taken, snap;

    ams_host_model host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));
    ams_sequencer #(.SETTLE_CYCLES(SETTLE_SIM)) dut (
        .clock(clock), .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
        .scan_enable(scan_enable), .range_sel(range_sel),
        .reference_source_select(reference_source_select), .sample_ready(sample_ready),
        .sample_valid(sample_valid), .sample_data(sample_data), .mode(mode),
        .ref_power_on(ref_power_on), .core_power_on(core_power_on),
        .channel_power(channel_power), .wake_busy(wake_busy), .settle_busy(settle_busy),
        .data_invalid(data_invalid), .sample_lost(sample_lost));

    // 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // count dropped requests and words handed to the converter
    always @(posedge clock) begin
        if (sample_lost === 1'b1) lost++;
        if (sample_valid === 1'b1 && sample_ready === 1'b1) taken++;
    end

    // next enabled channel of the scan, or the lowest when restarting
    function automatic logic [2:0] nxt(input logic [2:0] c, input bit rst);
        logic [2:0] k;
        for (int i = 0; i < NCH; i++) begin
            k = rst ? 3'(i) : 3'(c + 1 + i);
            if (scan_enable[k]) return k;
        end
        return c;
    endfunction

    // wait for a queued sample, compare channel and range, then accept it
    task automatic take(input logic ax, input logic [2:0] ch);
        int n;
        n = 0;
        while (sample_valid !== 1'b1 && n < 40) begin
            @(negedge clock);
            n++;
        end
        `CHK(sample_valid, 1'b1)
        `CHK({sample_data.aux, sample_data.chan, sample_data.range, sample_data.settled},
             {ax, ch, ax ? 4'h0 : range_sel[ch], settled_exp})
        @(posedge clock) sample_ready <= 1'b1;
        @(posedge clock) sample_ready <= 1'b0;
    endtask

    // one frame; smp says a sample is due at its start, then track the channel
    task automatic xfer(input logic [15:0] w, input int nb, input int hold, input logic smp);
        host.frame(w, nb, hold);
        if (smp) take(cur_aux, cur_ch);
        if (nb >= CMD_BITS) begin
            if (w === CMD_AUTO) begin
                cur_aux = 1'b0;
                cur_ch = nxt(cur_ch, 1'b1);
                auto_on = 1'b1;
            end else if (w[15:13] === 3'b110 || w === CMD_AUX) begin
                cur_aux = w[13];
                cur_ch = w[12:10];
                auto_on = 1'b0;
            end else if (auto_on && smp) begin
                cur_ch = nxt(cur_ch, 1'b0);
            end
        end
        @(negedge clock);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // watchdog well beyond the expected run of about 10k cycles
    initial begin
        repeat (60000) @(posedge clock);
        err_total++;
        summarize();
    end

    initial begin
        resetn = 1'b0;
        sample_ready = 1'b0;
        reference_source_select = 1'b0;
        scan_enable = 8'hA5;
        {cur_aux, cur_ch, auto_on} = 5'h00;
        settled_exp = 1'b1;
        for (int i = 0; i < NCH; i++) range_sel[i] = 4'(i + 3);
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        repeat (6) @(negedge clock);
        `CHK(mode, AMS_IDLE)
        xfer(CMD_STANDBY, 16, 0, 1'b0);
        `CHK(mode, AMS_STANDBY)
        `CHK({ref_power_on, core_power_on}, 2'b10)
        xfer(CMD_KEEP, 16, 0, 1'b0);
        `CHK(mode, AMS_STANDBY)
        `CHK(data_invalid, 1'b0)
        xfer(CMD_KEEP, 32, 0, 1'b0);
        `CHK(data_invalid, 1'b1)
        xfer(16'hD000, 8, 0, 1'b0);
        `CHK(mode, AMS_STANDBY)
        xfer(16'hD400, 34, 0, 1'b0);
        `CHK(mode, AMS_MANUAL)
        `CHK(wake_busy, 1'b1)
        `CHK(channel_power, 8'h20)
        settled_exp = 1'b0; // this frame's sample is taken while the wake-up still runs
        xfer(CMD_KEEP, 16, WAKE_CYC, 1'b1);
        settled_exp = 1'b1;
        `CHK(wake_busy, 1'b0)
        xfer(CMD_KEEP, 16, 0, 1'b1);
        for (int c = 0; c < NCH; c++) xfer(CMD_MAN_BASE | 16'(c << MAN_CH_LSB), 16, 0, 1'b1);
        xfer(CMD_AUX, 16, 0, 1'b1);
        xfer(CMD_AUTO, 34, 0, 1'b1);
        `CHK(mode, AMS_AUTO)
        `CHK(channel_power, scan_enable)
        repeat (2) xfer(CMD_KEEP, 16, 0, 1'b1);
        xfer(CMD_AUTO, 16, 0, 1'b1);
        repeat (5) xfer(CMD_KEEP, 16, 0, 1'b1);
        xfer(CMD_POWERDOWN, 16, 0, 1'b1);
        `CHK(mode, AMS_POWERDOWN)
        `CHK({ref_power_on, core_power_on}, 2'b00)
        xfer(CMD_KEEP, 32, 0, 1'b0);
        `CHK(mode, AMS_POWERDOWN)
        `CHK(data_invalid, 1'b1)
        xfer(16'hC800, 34, 0, 1'b0);
        `CHK(mode, AMS_MANUAL)
        `CHK(settle_busy, 1'b1)
        repeat (SETTLE_SIM) @(negedge clock);
        `CHK(settle_busy, 1'b0)
        xfer(CMD_KEEP, 16, 0, 1'b1);
        // stall the converter until the buffer refuses, then drain it empty
        lost = 0;
        repeat (FIFO_DEPTH + 4) host.frame(CMD_KEEP, 16, 0);
        `CHK(lost > 0, 1'b1)
        snap = taken;
        @(posedge clock) sample_ready <= 1'b1;
        repeat (100) @(posedge clock);
        sample_ready <= 1'b0;
        @(negedge clock);
        `CHK(taken - snap >= FIFO_DEPTH, 1'b1)
        `CHK(sample_valid, 1'b0)
        summarize();
    end
endmodule
